//--- hw/pcr_pkg.sv
// Constants, field layout and reset values of the pad control registers
package pcr_pkg;

   // Pads served by this block and the register stride
   localparam int          PCR_FIRST_PAD    = 2;
   localparam int          PCR_LAST_PAD     = 7;
   localparam int          PCR_NUM_PADS     = PCR_LAST_PAD - PCR_FIRST_PAD + 1;
   localparam int          PCR_PAD0_OFFSET  = 0;
   localparam int          PCR_REG_STRIDE   = 4;
   localparam int          PCR_ADDR_W       = 8;
   localparam int          PCR_DATA_W       = 32;

   // Byte offsets of the registers
   localparam logic [7:0]  PCR_PAD2_CONFIG  = 8'h08;
   localparam logic [7:0]  PCR_PAD3_CONFIG  = 8'h0c;
   localparam logic [7:0]  PCR_PAD4_CONFIG  = 8'h10;
   localparam logic [7:0]  PCR_PAD5_CONFIG  = 8'h14;
   localparam logic [7:0]  PCR_PAD6_CONFIG  = 8'h18;
   localparam logic [7:0]  PCR_PAD7_CONFIG  = 8'h1c;

   // Field positions
   localparam int          PCR_FSEL_LSB     = 0;
   localparam int          PCR_CSRC_LSB     = 3;
   localparam int          PCR_OENL_BIT     = 5;
   localparam int          PCR_PULL_LSB     = 6;
   localparam int          PCR_DRV_LSB      = 8;
   localparam int          PCR_SLEW_BIT     = 10;
   localparam int          PCR_RXEN_BIT     = 11;
   localparam int          PCR_HYST_BIT     = 12;
   localparam int          PCR_BYTE_W       = 8;

   // Implemented bits; bit 2 and bits 31:13 are not stored
   localparam logic [31:0] PCR_IMPL_MASK    = 32'h0000_1ffb;

   // Control source codes
   localparam logic [1:0]  PCR_CSRC_AO      = 2'h0;
   localparam logic [1:0]  PCR_CSRC_PERIPH  = 2'h1;
   localparam logic [1:0]  PCR_CSRC_FABRIC  = 2'h2;

   // Pull mode codes
   localparam logic [1:0]  PCR_PULL_Z       = 2'h0;
   localparam logic [1:0]  PCR_PULL_UP      = 2'h1;
   localparam logic [1:0]  PCR_PULL_DOWN    = 2'h2;
   localparam logic [1:0]  PCR_PULL_KEEP    = 2'h3;

   // Function code that hands pads 5 and 6 to the sensor engine
   localparam logic [1:0]  PCR_FSEL_SENSOR  = 2'h2;
   localparam int          PCR_SENSOR_PAD_A = 5;
   localparam int          PCR_SENSOR_PAD_B = 6;
   localparam int          PCR_PERIPH_PAD   = 6;

   // Field reset values
   localparam logic [1:0]  PCR_FSEL_RST     = 2'h0;
   localparam logic [1:0]  PCR_CSRC_RST     = 2'h0;
   localparam logic [1:0]  PCR_CSRC_RST_P6  = 2'h1;
   localparam logic        PCR_OENL_RST     = 1'b1;
   localparam logic [1:0]  PCR_PULL_RST     = 2'h0;
   localparam logic [1:0]  PCR_DRV_RST      = 2'h1;
   localparam logic        PCR_SLEW_RST     = 1'b0;
   localparam logic        PCR_RXEN_RST     = 1'b0;
   localparam logic        PCR_HYST_RST     = 1'b0;

endpackage : pcr_pkg

//--- hw/pcr_top.sv
// Pad control registers for pads 2 to 7 behind a classic Wishbone slave
`timescale 1ns/100ps
`default_nettype none

// How it works
// RL1: Bits 1:0 pick the pad output function.
// RL2: Bits 4:3 pick the output control source.
// RL3: Pads 5,6 hand control to sensor engine.
// RL4: Bit 5 disables driver when set; resets set.
// RL5: Bits 7:6 pull mode, reset high impedance.
// RL6: Bits 9:8 drive strength code, resets to 4mA.
// RL7: Bit 10 fast slew when set, resets slow.
// RL8: Bit 11 receiver enable, resets disabled.
// RL9: Bit 12 hysteresis input enable, resets disabled.
// RL10: Pad 6 source resets peripheral; fields read-write.
// RL11: One word per pad, pad 0 at zero.
// RL12: Unused bits read zero, writes ignored.
module pcr_top #(
   parameter int NUM_PADS = pcr_pkg::PCR_NUM_PADS,
   parameter int ADDR_W   = pcr_pkg::PCR_ADDR_W
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [ADDR_W-1:0]          wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output var  logic [31:0]                wb_dat_o,
   output var  logic                       wb_ack_o,
   output var  logic [NUM_PADS-1:0][1:0]   output_function_select_o,
   output var  logic [NUM_PADS-1:0][1:0]   pad_ctrl_source_o,
   output var  logic [NUM_PADS-1:0]        sensor_processing_engine_o,
   output var  logic [NUM_PADS-1:0]        output_enable_low_o,
   output var  logic [NUM_PADS-1:0][1:0]   pad_pull_mode_o,
   output var  logic [NUM_PADS-1:0][1:0]   pad_drive_strength_o,
   output var  logic [NUM_PADS-1:0]        slew_fast_o,
   output var  logic [NUM_PADS-1:0]        pad_rx_enable_o,
   output var  logic [NUM_PADS-1:0]        hysteresis_enable_o
);
   import pcr_pkg::*;

   // Word index starts above the byte lanes of one register
   localparam int WORD_LSB = $clog2(PCR_REG_STRIDE);
   localparam int IDX_W    = ADDR_W - WORD_LSB;

   // Reset word of one pad register
   function automatic logic [31:0] pcr_reset_word(input int pad);
      logic [31:0] w;
      w = '0;
      w[PCR_FSEL_LSB +: 2] = PCR_FSEL_RST;
      w[PCR_CSRC_LSB +: 2] = (pad == PCR_PERIPH_PAD) ?
                              PCR_CSRC_RST_P6 : PCR_CSRC_RST; // RL10
      w[PCR_OENL_BIT]      = PCR_OENL_RST;  // RL4
      w[PCR_PULL_LSB +: 2] = PCR_PULL_RST;  // RL5
      w[PCR_DRV_LSB +: 2]  = PCR_DRV_RST;   // RL6
      w[PCR_SLEW_BIT]      = PCR_SLEW_RST;  // RL7
      w[PCR_RXEN_BIT]      = PCR_RXEN_RST;  // RL8
      w[PCR_HYST_BIT]      = PCR_HYST_RST;  // RL9
      return w;
   endfunction : pcr_reset_word

   // Merge write data into a word under the byte lanes
   function automatic logic [31:0] pcr_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
      logic [31:0] m;
      m = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            m[b*PCR_BYTE_W +: PCR_BYTE_W] = new_w[b*PCR_BYTE_W +: PCR_BYTE_W];
         end
      end
      // Unstored bits are cleared so a wide write cannot leave them set
      return m & PCR_IMPL_MASK; // RL12
   endfunction : pcr_merge

   // Whether a pad register hands control to the sensor engine
   function automatic logic pcr_sensor_take(input int pad,
                                            input logic [31:0] w);
      logic capable;
      capable = (pad == PCR_SENSOR_PAD_A) || (pad == PCR_SENSOR_PAD_B);
      return capable && (w[PCR_CSRC_LSB +: 2] == PCR_CSRC_AO) &&
             (w[PCR_FSEL_LSB +: 2] == PCR_FSEL_SENSOR); // RL3
   endfunction : pcr_sensor_take

   logic [NUM_PADS-1:0][31:0] pad_reg_r;
   logic [NUM_PADS-1:0][31:0] pad_reg_nxt;
   logic [NUM_PADS-1:0]       sensor_r;
   logic [NUM_PADS-1:0]       sensor_nxt;
   logic [31:0]               dat_r;
   logic                      ack_r;

   wire  logic [IDX_W-1:0]    word_idx;
   wire  logic                bus_req;
   wire  logic                addr_mapped;
   wire  logic [IDX_W-1:0]    slot;
   wire  logic [31:0]         rd_word;
   wire  logic [NUM_PADS-1:0] wr_hit;
   wire  logic                ack_nxt;

   // Address decode: word index, range check and slot in the array
   assign word_idx    = wb_adr_i[ADDR_W-1:WORD_LSB];  // RL11
   // An ack in flight keeps a held request from being taken twice
   assign bus_req     = wb_cyc_i && wb_stb_i && !ack_r;
   assign addr_mapped = (word_idx >= IDX_W'(PCR_FIRST_PAD)) &&
                        (word_idx <= IDX_W'(PCR_FIRST_PAD + NUM_PADS - 1));
   assign slot        = word_idx - IDX_W'(PCR_FIRST_PAD);  // RL11
   assign rd_word     = addr_mapped ? pad_reg_r[slot] : 32'h0000_0000;
   assign ack_nxt     = bus_req;

   // Write strobes, one per pad register
   genvar g;
   generate
      for (g = 0; g < NUM_PADS; g++) begin : g_hit
         assign wr_hit[g] = bus_req && wb_we_i && addr_mapped &&
                            (slot == IDX_W'(g));
      end
   endgenerate

   // Next register contents and sensor hand-over flags
   always_comb begin
      for (int i = 0; i < NUM_PADS; i++) begin
         pad_reg_nxt[i] = wr_hit[i] ?
                          pcr_merge(pad_reg_r[i], wb_dat_i, wb_sel_i) :
                          pad_reg_r[i]; // RL10
         sensor_nxt[i]  = pcr_sensor_take(i + PCR_FIRST_PAD, pad_reg_nxt[i]);
      end
   end

   // Register storage
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NUM_PADS; i++) begin
         if (rst_i) begin
            pad_reg_r[i] <= pcr_reset_word(i + PCR_FIRST_PAD);
         end else begin
            pad_reg_r[i] <= pad_reg_nxt[i];
         end
      end
   end

   // Sensor hand-over flag, aligned with the stored register
   // Fed from the next value so the flag never lags the stored word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sensor_r <= '0;
      end else begin
         sensor_r <= sensor_nxt;  // RL3
      end
   end

   // Bus answer: one-cycle ack, read data zero for unmapped words
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= ack_nxt;
         // Read data falls back to zero so no stale word lingers
         dat_r <= (bus_req && !wb_we_i) ? rd_word : 32'h0000_0000; // RL12
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // Field outputs taken straight from the stored registers
   always_comb begin
      for (int i = 0; i < NUM_PADS; i++) begin
         output_function_select_o[i] = pad_reg_r[i][PCR_FSEL_LSB +: 2]; // RL1
         pad_ctrl_source_o[i]        = pad_reg_r[i][PCR_CSRC_LSB +: 2]; // RL2
         output_enable_low_o[i]      = pad_reg_r[i][PCR_OENL_BIT];      // RL4
         pad_pull_mode_o[i]          = pad_reg_r[i][PCR_PULL_LSB +: 2]; // RL5
         pad_drive_strength_o[i]     = pad_reg_r[i][PCR_DRV_LSB +: 2];  // RL6
         slew_fast_o[i]              = pad_reg_r[i][PCR_SLEW_BIT];      // RL7
         pad_rx_enable_o[i]          = pad_reg_r[i][PCR_RXEN_BIT];      // RL8
         hysteresis_enable_o[i]      = pad_reg_r[i][PCR_HYST_BIT];      // RL9
      end
   end
   assign sensor_processing_engine_o = sensor_r;

   // Bus handshake and unmapped read checks
   chk_ack_single_pulse: assert property (  // RL11
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   chk_ack_after_req: assert property (  // RL11
      @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");

   chk_unmapped_reads_zero: assert property (  // RL12
      @(posedge clk_i) disable iff (rst_i)
      (bus_req && !wb_we_i && !addr_mapped) |=> (wb_dat_o == 32'h0000_0000))
      else $error("unmapped read returned nonzero data");

   // Reset values, seen at the edge after each edge with reset high
   chk_reset_oen_high: assert property (  // RL4
      @(posedge clk_i)
      $past(rst_i) |-> (output_enable_low_o == {NUM_PADS{PCR_OENL_RST}}))
      else $error("output enable low not set after reset");

   chk_reset_drive_code: assert property (  // RL6
      @(posedge clk_i)
      $past(rst_i) |-> (pad_drive_strength_o == {NUM_PADS{PCR_DRV_RST}}))
      else $error("drive strength wrong after reset");

   chk_reset_input_side: assert property (  // RL8
      @(posedge clk_i)
      $past(rst_i) |-> (pad_rx_enable_o == '0 && hysteresis_enable_o == '0
                        && slew_fast_o == '0 && pad_pull_mode_o == '0))
      else $error("input side fields wrong after reset");

   chk_reset_pad6_source: assert property (  // RL10
      @(posedge clk_i)
      $past(rst_i) |->
         (pad_ctrl_source_o[PCR_PERIPH_PAD-PCR_FIRST_PAD] == PCR_CSRC_PERIPH)
         && (pad_ctrl_source_o[0] == PCR_CSRC_AO))
      else $error("control source reset value wrong");

   chk_reset_bus_idle: assert property (  // RL11
      @(posedge clk_i)
      $past(rst_i) |-> (!wb_ack_o && wb_dat_o == 32'h0000_0000))
      else $error("bus answer not idle after reset");

   chk_reset_function_zero: assert property (  // RL1
      @(posedge clk_i)
      $past(rst_i) |-> (output_function_select_o == '0 &&
                        sensor_processing_engine_o == '0))
      else $error("function select or hand-over set after reset");

   // Read data, ack and write decode checks
   chk_dat_idle_zero: assert property (  // RL12
      @(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
      else $error("read data not zero outside ack");

   chk_ack_needs_req: assert property (  // RL11
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");

   chk_write_ack_dat_zero: assert property (  // RL12
      @(posedge clk_i) disable iff (rst_i)
      (bus_req && wb_we_i) |=> (wb_dat_o == 32'h0000_0000))
      else $error("write answered with nonzero data");

   chk_one_write_hit: assert property (  // RL11
      @(posedge clk_i) disable iff (rst_i)
      $onehot0(wr_hit))
      else $error("write decoded to more than one register");

   chk_unmapped_no_hit: assert property (  // RL12
      @(posedge clk_i) disable iff (rst_i)
      (bus_req && !addr_mapped) |-> (wr_hit == '0))
      else $error("unmapped write hit a register");

   // Per-pad checks on writes, readback, routing and reset source
   generate
      for (g = 0; g < NUM_PADS; g++) begin : g_chk
         chk_low_byte_write: assert property (  // RL1
            @(posedge clk_i) disable iff (rst_i)
            (wr_hit[g] && wb_sel_i[0]) |=>
               (output_function_select_o[g] == $past(wb_dat_i[1:0])) &&
               (pad_ctrl_source_o[g] == $past(wb_dat_i[4:3])) &&
               (pad_pull_mode_o[g] == $past(wb_dat_i[7:6])))
            else $error("low byte write not stored");

         chk_high_byte_write: assert property (  // RL7
            @(posedge clk_i) disable iff (rst_i)
            (wr_hit[g] && wb_sel_i[1]) |=>
               ({hysteresis_enable_o[g], pad_rx_enable_o[g], slew_fast_o[g],
                 pad_drive_strength_o[g]} == $past(wb_dat_i[12:8])))
            else $error("high byte write not stored");

         chk_lane_untouched: assert property (  // RL9
            @(posedge clk_i) disable iff (rst_i)
            (wr_hit[g] && !wb_sel_i[1]) |=>
               $stable(pad_drive_strength_o[g]) && $stable(pad_rx_enable_o[g]))
            else $error("disabled byte lane changed a field");

         chk_unused_bits_zero: assert property (  // RL12
            @(posedge clk_i) disable iff (rst_i)
            (pad_reg_r[g] & ~PCR_IMPL_MASK) == 32'h0000_0000)
            else $error("unused register bits not zero");

         chk_readback_word: assert property (  // RL11
            @(posedge clk_i) disable iff (rst_i)
            (bus_req && !wb_we_i && addr_mapped && slot == IDX_W'(g)) |=>
               (wb_dat_o == pad_reg_r[g]))
            else $error("readback differs from stored word");

         chk_sensor_route: assert property (  // RL3
            @(posedge clk_i) disable iff (rst_i)
            sensor_processing_engine_o[g] ==
               (((g + PCR_FIRST_PAD) == PCR_SENSOR_PAD_A ||
                 (g + PCR_FIRST_PAD) == PCR_SENSOR_PAD_B) &&
                pad_ctrl_source_o[g] == PCR_CSRC_AO &&
                output_function_select_o[g] == PCR_FSEL_SENSOR))
            else $error("sensor engine hand-over wrong");

         chk_fields_hold: assert property (  // RL2
            @(posedge clk_i) disable iff (rst_i)
            !wr_hit[g] |=> $stable(pad_reg_r[g]))
            else $error("register changed without a write");

         chk_pull_keeper: assert property (  // RL5
            @(posedge clk_i) disable iff (rst_i)
            (wr_hit[g] && wb_sel_i[0] &&
             wb_dat_i[PCR_PULL_LSB +: 2] == PCR_PULL_KEEP) |=>
               pad_pull_mode_o[g] == PCR_PULL_KEEP)
            else $error("keeper mode not stored");

         chk_oen_write: assert property (  // RL4
            @(posedge clk_i) disable iff (rst_i)
            (wr_hit[g] && wb_sel_i[0]) |=>
               (output_enable_low_o[g] == $past(wb_dat_i[PCR_OENL_BIT])))
            else $error("output enable low write not stored");

         chk_low_lane_held: assert property (  // RL1
            @(posedge clk_i) disable iff (rst_i)
            (wr_hit[g] && !wb_sel_i[0]) |=>
               $stable(output_function_select_o[g]) &&
               $stable(pad_ctrl_source_o[g]) &&
               $stable(output_enable_low_o[g]) && $stable(pad_pull_mode_o[g]))
            else $error("disabled low lane changed a field");

         chk_slew_hyst_held: assert property (  // RL9
            @(posedge clk_i) disable iff (rst_i)
            (wr_hit[g] && !wb_sel_i[1]) |=>
               $stable(slew_fast_o[g]) && $stable(hysteresis_enable_o[g]))
            else $error("disabled high lane changed slew or hysteresis");

         chk_reset_source: assert property (  // RL10
            @(posedge clk_i)
            $past(rst_i) |-> (pad_ctrl_source_o[g] ==
               ((g + PCR_FIRST_PAD == PCR_PERIPH_PAD) ? PCR_CSRC_RST_P6 :
                                                        PCR_CSRC_RST)))
            else $error("control source reset value wrong for this pad");
      end
   endgenerate

endmodule : pcr_top

`default_nettype wire

//--- verif/pcr_top_tb.sv
// Self-checking bench for the pad control registers over classic Wishbone
`timescale 1ns/100ps
`default_nettype none

module pcr_top_tb;
   import pcr_pkg::*;

   logic                     clk_i;
   logic                     rst_i;
   logic                     wb_cyc_i;
   logic                     wb_stb_i;
   logic                     wb_we_i;
   logic [7:0]               wb_adr_i;
   logic [3:0]               wb_sel_i;
   logic [31:0]              wb_dat_i;
   logic [31:0]              wb_dat_o;
   logic                     wb_ack_o;
   logic [5:0][1:0]          fsel;
   logic [5:0][1:0]          csrc;
   logic [5:0]               sensor;
   logic [5:0]               oen_low;
   logic [5:0][1:0]          pull;
   logic [5:0][1:0]          drive;
   logic [5:0]               slew;
   logic [5:0]               rx_en;
   logic [5:0]               hyst;
   int                       errors;
   int                       num_checks;
   int                       i;
   int                       k;
   logic [7:0]               a;
   logic [31:0]              e;

   pcr_top i_pcr_top (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .output_function_select_o(fsel),
      .pad_ctrl_source_o(csrc), .sensor_processing_engine_o(sensor),
      .output_enable_low_o(oen_low), .pad_pull_mode_o(pull),
      .pad_drive_strength_o(drive), .slew_fast_o(slew),
      .pad_rx_enable_o(rx_en), .hysteresis_enable_o(hyst));

   // Clock at 100 MHz
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Prints the verdict and ends the run
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One classic cycle; waits for ack, the watchdog bounds the wait
   task automatic wb_xfer(input logic we, input logic [7:0] adr,
                          input logic [31:0] dat, input logic [3:0] sel,
                          output logic [31:0] rd);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb_xfer

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel);
      logic [31:0] rd;
      wb_xfer(1'b1, adr, dat, sel, rd);
   endtask : wr

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb_xfer(1'b0, adr, 32'h0000_0000, 4'hf, rd);
      check(rd, exp);
   endtask : rd_chk

   // Compares every pad output field of one pad with a register word
   task automatic chk_pad(input int p, input logic [31:0] w);
      check({fsel[p], csrc[p], oen_low[p], pull[p], drive[p], slew[p],
             rx_en[p], hyst[p]},
            {w[1:0], w[4:3], w[5], w[7:6], w[9:8], w[10], w[11], w[12]});
   endtask : chk_pad

   // Watchdog
   initial begin
      #100000;
      errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      test_done;
   end

   // Main sequence
   initial begin
      errors = 0;
      num_checks = 0;
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values of every register and pad output
      for (i = 0; i < 6; i++) begin
         a = PCR_PAD2_CONFIG + 8'(4 * i);
         e = (i == 4) ? 32'h0000_0128 : 32'h0000_0120;
         rd_chk(a, e);
         chk_pad(i, e);
      end
      check(32'(sensor), 32'h0000_0000);
      $display("reset test done");
      // All ones: only implemented bits stick
      for (i = 0; i < 6; i++) begin
         a = PCR_PAD2_CONFIG + 8'(4 * i);
         wr(a, 32'hffff_ffff, 4'hf);
         rd_chk(a, 32'h0000_1ffb);
         chk_pad(i, 32'h0000_1ffb);
      end
      $display("write test done");
      // Every code of the two-bit fields on pad 7
      for (k = 0; k < 4; k++) begin
         e = 32'(k) * 32'h0000_0149;
         wr(PCR_PAD7_CONFIG, e, 4'hf);
         rd_chk(PCR_PAD7_CONFIG, e);
         chk_pad(5, e);
      end
      $display("code test done");
      // Sensor engine takes pads 5 and 6 only with source 0, function 2
      for (i = 2; i < 5; i++)
         wr(PCR_PAD2_CONFIG + 8'(4 * i), 32'h0000_0002, 4'hf);
      check(32'(sensor), 32'h0000_0018);
      wr(PCR_PAD5_CONFIG, 32'h0000_0001, 4'hf);
      check(32'(sensor), 32'h0000_0010);
      wr(PCR_PAD6_CONFIG, 32'h0000_000a, 4'hf);
      check(32'(sensor), 32'h0000_0000);
      $display("sensor test done");
      // Byte lanes, then unmapped places
      wr(PCR_PAD3_CONFIG, 32'h0000_0000, 4'h1);
      rd_chk(PCR_PAD3_CONFIG, 32'h0000_1f00);
      wr(PCR_PAD3_CONFIG, 32'h0000_0000, 4'hc);
      rd_chk(PCR_PAD3_CONFIG, 32'h0000_1f00);
      wr(PCR_PAD3_CONFIG, 32'h0000_0000, 4'h2);
      rd_chk(PCR_PAD3_CONFIG, 32'h0000_0000);
      chk_pad(1, 32'h0000_0000);
      wr(8'h00, 32'hffff_ffff, 4'hf);
      wr(8'h20, 32'hffff_ffff, 4'hf);
      rd_chk(8'h00, 32'h0000_0000);
      rd_chk(8'h20, 32'h0000_0000);
      rd_chk(PCR_PAD2_CONFIG, 32'h0000_1ffb);
      $display("lane test done");
      // Reset in mid-run clears the hand-over and returns every register to its reset word
      wr(PCR_PAD5_CONFIG, 32'h0000_0002, 4'hf);
      check(32'(sensor), 32'h0000_0008);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 6; i++) begin
         e = (i == 4) ? 32'h0000_0128 : 32'h0000_0120;
         rd_chk(PCR_PAD2_CONFIG + 8'(4 * i), e);
         chk_pad(i, e);
      end
      check(32'(sensor), 32'h0000_0000);
      $display("second reset test done");
      test_done;
   end

endmodule : pcr_top_tb

`default_nettype wire
